// [src/flash_host_pkg.sv]
// Purpose: constants for the boot-block flash host controller
// Assumes: 100 MHz clock, asynchronous flash bus driven from flip-flops
// Notes: command codes, status bit positions, own register map, bus timing
package flash_host_pkg;
  // ==========================================================
  // flash command codes
  localparam logic [7:0] cmd_read_array = 8'h00_FF;
  localparam logic [7:0] cmd_read_id = 8'h00_90;
  localparam logic [7:0] cmd_read_status = 8'h00_70;
  localparam logic [7:0] cmd_clear_status = 8'h00_50;
  localparam logic [7:0] cmd_program_setup = 8'h00_40;
  localparam logic [7:0] cmd_program_alt = 8'h00_10;
  localparam logic [7:0] cmd_erase_setup = 8'h00_20;
  localparam logic [7:0] cmd_erase_confirm = 8'h00_D0;
  localparam logic [7:0] cmd_erase_suspend = 8'h00_B0;
  localparam logic [7:0] cmd_erase_resume = 8'h00_D0;
  // ==========================================================
  // flash status bit positions
  localparam int supply_fault_flag = 3;
  localparam int program_fail_flag = 4;
  localparam int erase_fail_flag = 5;
  localparam int suspended_flag = 6;
  localparam int sequencer_ready_flag = 7;
  // ==========================================================
  // host register map (word offsets of the software port)
  localparam logic [3:0] reg_addr_off = 4'h0;
  localparam logic [3:0] reg_wdata_off = 4'h1;
  localparam logic [3:0] reg_cmd_off = 4'h2;
  localparam logic [3:0] reg_status_off = 4'h3;
  localparam logic [3:0] reg_rdata_off = 4'h4;
  localparam logic [3:0] reg_ctrl_off = 4'h5;
  // host command encodings written to reg_cmd_off
  localparam logic [3:0] op_read = 4'h1;
  localparam logic [3:0] op_read_id = 4'h2;
  localparam logic [3:0] op_read_status = 4'h3;
  localparam logic [3:0] op_clear_status = 4'h4;
  localparam logic [3:0] op_program = 4'h5;
  localparam logic [3:0] op_erase = 4'h6;
  localparam logic [3:0] op_suspend = 4'h7;
  localparam logic [3:0] op_resume = 4'h8;
  localparam logic [3:0] op_abort_program = 4'h9;
  localparam logic [3:0] op_read_array = 4'h0;
  // ctrl register bits
  localparam int ctrl_word_bit = 0;
  localparam int ctrl_reset_bit = 1;
  // word mode, flash reset pin released, so commands can start after reset
  localparam logic [1:0] ctrl_reset_value = 2'h3;
  // ==========================================================
  // bus timing: strobe low time and gap, in ns and cycles
  localparam int clk_period_ns = 10;
  localparam int strobe_low_ns = 90;
  localparam int strobe_gap_ns = 30;
  localparam int strobe_low_cycles = (strobe_low_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int strobe_gap_cycles = (strobe_gap_ns + clk_period_ns - 1) / clk_period_ns;
endpackage

// [src/flash_host.sv]
// Purpose: host that drives a boot-block flash through its asynchronous pins
// Assumes: software issues one operation at a time and polls status
// Notes: every flash pin and output comes straight from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module flash_host
  import flash_host_pkg::*;
#(
  parameter int addr_width = 17,
  parameter int data_width = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_write,
  input wire logic sw_read,
  output logic [31:0] sw_rdata,
  // flash pins
  output logic [addr_width-1:0] flash_addr,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic reset_powerdown_n,
  output logic byte_mode_n,
  input wire logic [data_width-1:0] data_io_bus_in,
  output logic [data_width-1:0] data_io_bus_out,
  output logic data_io_bus_oe
);
  // ==========================================================
  // elaboration checks
  initial begin
    if (data_width != 16 || addr_width < 1 || addr_width > 32) begin
      $error("flash_host: unsupported width");
    end
  end

  // ==========================================================
  // state
  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_wr_low = 4'b0001,
    st_wr_gap = 4'b0010,
    st_rd_low = 4'b0011,
    st_rd_gap = 4'b0100,
    st_poll_low = 4'b0101,
    st_poll_gap = 4'b0110
  } state_t;

  typedef enum logic [1:0] {
    fl_array = 2'b00,
    fl_busy = 2'b01,
    fl_suspended = 2'b10
  } flash_mode_t;

  state_t state_reg;
  flash_mode_t mode_reg;
  logic [addr_width-1:0] target_reg;
  logic [data_width-1:0] wdata_reg;
  logic [3:0] op_reg;
  logic [1:0] step_reg;
  logic [7:0] count_reg;
  logic [1:0] ctrl_reg;
  logic busy_reg;
  logic error_reg;
  logic [7:0] status_reg;
  logic [data_width-1:0] rdata_reg;
  logic start;
  logic op_legal;
  logic [7:0] cur_code;
  logic [1:0] steps;
  logic last_step;

  assign start = sw_write && sw_addr == reg_cmd_off && !busy_reg;

  // which host ops the flash will honour in its present mode
  always_comb begin
    op_legal = 1'b1;
    case (mode_reg)
      fl_busy: op_legal = (sw_wdata[3:0] == op_read_status) ||
                          (sw_wdata[3:0] == op_suspend);
      fl_suspended: op_legal = (sw_wdata[3:0] == op_read_array) || (sw_wdata[3:0] == op_read) ||
                               (sw_wdata[3:0] == op_read_status) ||
                               (sw_wdata[3:0] == op_resume);
      default: op_legal = (sw_wdata[3:0] != op_suspend) && (sw_wdata[3:0] != op_resume);
    endcase
  end

  // command code for each write step of the current op
  always_comb begin
    cur_code = cmd_read_array;
    steps = 2'd1;
    case (op_reg)
      op_read: cur_code = cmd_read_array;
      op_read_id: cur_code = cmd_read_id;
      op_read_status: cur_code = cmd_read_status;
      op_clear_status: cur_code = cmd_clear_status;
      op_program, op_abort_program: begin
        cur_code = cmd_program_setup;
        steps = 2'd2;
      end
      op_erase: begin
        cur_code = (step_reg == 2'd0) ? cmd_erase_setup : cmd_erase_confirm;
        steps = 2'd2;
      end
      op_suspend: cur_code = cmd_erase_suspend;
      op_resume: cur_code = cmd_erase_resume;
      default: cur_code = cmd_read_array;
    endcase
  end

  assign last_step = (step_reg == steps - 2'd1);

  // ==========================================================
  // software registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      target_reg <= '0;
      wdata_reg <= '0;
      ctrl_reg <= ctrl_reset_value;
    end else if (sw_write && !busy_reg) begin
      case (sw_addr)
        reg_addr_off: target_reg <= sw_wdata[addr_width-1:0];
        reg_wdata_off: wdata_reg <= sw_wdata[data_width-1:0];
        reg_ctrl_off: ctrl_reg <= sw_wdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sw_rdata <= '0;
    end else if (sw_read) begin
      case (sw_addr)
        reg_addr_off: sw_rdata <= 32'(target_reg);
        reg_wdata_off: sw_rdata <= 32'(wdata_reg);
        reg_status_off: sw_rdata <= {20'h0_0000, 2'(mode_reg), error_reg, busy_reg, status_reg};
        reg_rdata_off: sw_rdata <= 32'(rdata_reg);
        reg_ctrl_off: sw_rdata <= 32'(ctrl_reg);
        default: sw_rdata <= '0;
      endcase
    end else begin
      sw_rdata <= '0;
    end
  end

  // ==========================================================
  // pins that follow control
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reset_powerdown_n <= 1'b0;
      byte_mode_n <= 1'b1;
    end else begin
      reset_powerdown_n <= ctrl_reg[ctrl_reset_bit];
      byte_mode_n <= ctrl_reg[ctrl_word_bit];
    end
  end

  // ==========================================================
  // bus sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= st_idle;
      op_reg <= op_read_array;
      step_reg <= 2'd0;
      count_reg <= '0;
      busy_reg <= 1'b0;
      error_reg <= 1'b0;
      chip_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      flash_addr <= '0;
      data_io_bus_out <= '0;
      data_io_bus_oe <= 1'b0;
    end else begin
      case (state_reg)
        st_idle: begin
          if (start && op_legal && ctrl_reg[ctrl_reset_bit]) begin
            op_reg <= sw_wdata[3:0];
            step_reg <= 2'd0;
            busy_reg <= 1'b1;
            error_reg <= 1'b0;
            flash_addr <= target_reg;
            if (sw_wdata[3:0] == op_read && mode_reg == fl_array) begin
              state_reg <= st_rd_low; // array already selected
              chip_enable_n <= 1'b0;
              output_enable_n <= 1'b0;
            end else begin
              state_reg <= st_wr_low;
              chip_enable_n <= 1'b0;
              write_enable_n <= 1'b0;
              data_io_bus_oe <= 1'b1;
            end
            count_reg <= 8'(strobe_low_cycles);
          end else if (start) begin
            error_reg <= 1'b1;
          end
          if (sw_wdata[3:0] == op_erase) begin
            data_io_bus_out <= 16'(cmd_erase_setup);
          end else begin
            data_io_bus_out <= 16'(sw_wdata[3:0] == op_program || sw_wdata[3:0] == op_abort_program ?
                                   cmd_program_setup : cmd_read_array);
          end
          if (start && op_legal) begin
            data_io_bus_out <= 16'(code_of(sw_wdata[3:0]));
          end
        end
        st_wr_low: begin
          if (count_reg > 8'd1) begin
            count_reg <= count_reg - 8'd1;
          end else begin
            // both strobes rise together, latching code and block address
            chip_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            count_reg <= 8'(strobe_gap_cycles);
            state_reg <= st_wr_gap;
          end
        end
        st_wr_gap: begin
          if (count_reg > 8'd1) begin
            count_reg <= count_reg - 8'd1;
          end else if (!last_step) begin
            step_reg <= step_reg + 2'd1;
            chip_enable_n <= 1'b0;
            write_enable_n <= 1'b0;
            if (op_reg == op_program) begin
              data_io_bus_out <= wdata_reg;
            end else if (op_reg == op_abort_program) begin
              data_io_bus_out <= '1;
            end else begin
              data_io_bus_out <= 16'(cmd_erase_confirm);
            end
            count_reg <= 8'(strobe_low_cycles);
            state_reg <= st_wr_low;
          end else begin
            data_io_bus_oe <= 1'b0;
            count_reg <= 8'(strobe_low_cycles);
            chip_enable_n <= 1'b0;
            output_enable_n <= 1'b0;
            case (op_reg)
              op_program, op_abort_program, op_erase, op_suspend: state_reg <= st_poll_low;
              op_read, op_read_id, op_read_status: state_reg <= st_rd_low;
              default: begin
                chip_enable_n <= 1'b1;
                output_enable_n <= 1'b1;
                busy_reg <= 1'b0;
                state_reg <= st_idle;
              end
            endcase
          end
        end
        st_rd_low, st_poll_low: begin
          if (count_reg > 8'd1) begin
            count_reg <= count_reg - 8'd1;
          end else begin
            chip_enable_n <= 1'b1; // fresh falling edge per poll
            output_enable_n <= 1'b1;
            count_reg <= 8'(strobe_gap_cycles);
            state_reg <= (state_reg == st_rd_low) ? st_rd_gap : st_poll_gap;
          end
        end
        st_rd_gap: begin
          if (count_reg > 8'd1) begin
            count_reg <= count_reg - 8'd1;
          end else begin
            busy_reg <= 1'b0; // pins idle afterwards
            state_reg <= st_idle;
          end
        end
        st_poll_gap: begin
          if (count_reg > 8'd1) begin
            count_reg <= count_reg - 8'd1;
          end else if (status_reg[sequencer_ready_flag]) begin
            busy_reg <= 1'b0;
            state_reg <= st_idle;
          end else begin
            chip_enable_n <= 1'b0;
            output_enable_n <= 1'b0;
            count_reg <= 8'(strobe_low_cycles);
            state_reg <= st_poll_low;
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  function automatic logic [7:0] code_of(input logic [3:0] op);
    case (op)
      op_read_id: code_of = cmd_read_id;
      op_read_status: code_of = cmd_read_status;
      op_clear_status: code_of = cmd_clear_status;
      op_program, op_abort_program: code_of = cmd_program_setup;
      op_erase: code_of = cmd_erase_setup;
      op_suspend: code_of = cmd_erase_suspend;
      op_resume: code_of = cmd_erase_resume;
      default: code_of = cmd_read_array;
    endcase
  endfunction

  // ==========================================================
  // data capture at the end of the low phase, mirrors of the flash mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
      status_reg <= 8'h00_80;
    end else if ((state_reg == st_rd_low || state_reg == st_poll_low) && count_reg == 8'd1) begin
      if (state_reg == st_poll_low || op_reg == op_read_status) begin
        status_reg <= {data_io_bus_in[7:3], 3'b000}; // ready, suspend and fault flags from flash, bits 2:0 zero
      end
      rdata_reg <= byte_mode_n ? data_io_bus_in : {8'h00, data_io_bus_in[7:0]};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_reg <= fl_array;
    end else if (!ctrl_reg[ctrl_reset_bit]) begin
      mode_reg <= fl_array;
    end else if (state_reg == st_poll_gap && count_reg == 8'd1 && status_reg[sequencer_ready_flag]) begin
      mode_reg <= (op_reg == op_suspend && status_reg[suspended_flag]) ? fl_suspended : fl_array;
    end else if (state_reg == st_wr_gap && count_reg == 8'd1 && last_step) begin
      case (op_reg)
        op_program, op_abort_program, op_erase, op_resume: mode_reg <= fl_busy;
        default: mode_reg <= mode_reg;
      endcase
    end
  end
endmodule
`default_nettype wire

// [test/flash_host_asserts.sv]
// Purpose: port checks on the flash host
// Assumes: one clock, reset async high
// Notes: strobe figures follow the hand-over timing
`timescale 1ns/1ps
`default_nettype none
module flash_host_asserts
  import flash_host_pkg::*;
#(
  parameter int addr_width = 17,
  parameter int data_width = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_write,
  input wire logic sw_read,
  input wire logic [31:0] sw_rdata,
  // flash pins
  input wire logic [addr_width-1:0] flash_addr,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic reset_powerdown_n,
  input wire logic byte_mode_n,
  input wire logic [data_width-1:0] data_io_bus_in,
  input wire logic [data_width-1:0] data_io_bus_out,
  input wire logic data_io_bus_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================
  // assertions
  strobe_excl_a: assert property (
    write_enable_n || output_enable_n) else $error("write and read strobes overlap");
  read_pins_a: assert property (
    !output_enable_n |-> !chip_enable_n && reset_powerdown_n && !data_io_bus_oe) else $error("bad read pins");
  write_drive_a: assert property (
    !write_enable_n |-> data_io_bus_oe && !chip_enable_n) else $error("write without drive");
  write_rp_a: assert property (
    !write_enable_n |-> reset_powerdown_n) else $error("write while flash held in reset");
  write_len_a: assert property (
    $fell(write_enable_n) |-> ##8 !write_enable_n ##1 write_enable_n) else $error("write strobe length");
  write_hold_a: assert property (
    !write_enable_n && $past(!write_enable_n) |-> $stable(flash_addr) && $stable(data_io_bus_out))
    else $error("address or data moved under write strobe");
  chip_gap_a: assert property (
    $rose(chip_enable_n) |=> chip_enable_n[*2]) else $error("chip strobe gap short");
  read_len_a: assert property (
    $fell(output_enable_n) |-> !output_enable_n[*8]) else $error("read strobe short");
  rdata_idle_a: assert property (
    !$past(sw_read) |-> sw_rdata == 32'h0) else $error("read data outside its cycle");
  // main scenarios
  cover property ($fell(write_enable_n));
  cover property ($fell(output_enable_n));
  cover property ($rose(reset_powerdown_n));
  cover property (!byte_mode_n && !output_enable_n);
endmodule
bind flash_host flash_host_asserts #(.addr_width(addr_width), .data_width(data_width)) chk (
  .clk(clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write),
  .sw_read(sw_read), .sw_rdata(sw_rdata), .flash_addr(flash_addr), .chip_enable_n(chip_enable_n),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .reset_powerdown_n(reset_powerdown_n),
  .byte_mode_n(byte_mode_n), .data_io_bus_in(data_io_bus_in), .data_io_bus_out(data_io_bus_out),
  .data_io_bus_oe(data_io_bus_oe));
`default_nettype wire

// [test/flash_model.sv]
// Purpose: behavioural flash at the far side of the host
// Assumes: commands taken when write or chip strobe rises after both were low
// Notes: completion worked out lazily from simulation time
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
  parameter int busy_ns = 2000,
  parameter logic [15:0] mfr_code = 16'h005a, // arbitrary value
  parameter logic [15:0] dev_code = 16'h00a6 // arbitrary value
) (
  // flash pins
  input wire logic [16:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rp_n,
  input wire logic byte_n,
  input wire logic [15:0] din,
  output logic [15:0] dout,
  // makes the next program fail
  input wire logic fail_next
);
  logic [15:0] mem [16];
  logic [15:0] pd, last, val;
  logic [7:0] stl, c;
  logic [2:0] fl, ph;
  logic [3:0] pa;
  logic [1:0] mode;
  logic wsel;
  time done_at, rem;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'h3c5a ^ (16'h0101 * 16'(i));
    ph = 0;
    mode = 0;
    fl = 0;
    wsel = 1'b0;
    stl = 8'h80;
    last = 16'h0000;
  end
  // ==========================================
  // sequencer: finishes once its time is up
  task automatic tick();
    if ((ph == 3 || ph == 4) && $time >= done_at) begin
      if (ph == 3 && fail_next) fl[1] = 1'b1;
      else if (ph == 3) mem[pa] = mem[pa] & pd;
      else for (int i = 0; i < 16; i++) if (i[3:2] == pa[3:2]) mem[i] = 16'hffff;
      ph = 0;
    end
  endtask
  // a write ends at whichever of chip or write strobe rises first
  always @(we_n or ce_n) begin
    if (wsel && (we_n || ce_n) && rp_n) begin
      c = din[7:0];
      tick();
      case (ph)
        3'd1: begin
          mode = 2'd2;
          pa = addr[3:0];
          pd = din;
          done_at = $time + busy_ns;
          ph = ((byte_n ? din : {8'hff, c}) == 16'hffff) ? 3'd0 : 3'd3;
        end
        3'd2: begin
          mode = 2'd2;
          pa = addr[3:0];
          done_at = $time + busy_ns;
          ph = (c == 8'hd0) ? 3'd4 : 3'd0;
        end
        3'd3: if (c == 8'h70) mode = 2'd2;
        3'd4: begin
          if (c == 8'h70) mode = 2'd2;
          if (c == 8'hb0) begin
            rem = done_at - $time;
            ph = 5;
            mode = 2'd2;
          end
        end
        3'd5: begin
          if (c == 8'hff) mode = 2'd0;
          if (c == 8'h70) mode = 2'd2;
          if (c == 8'hd0) begin
            done_at = $time + rem;
            ph = 4;
            mode = 2'd2;
          end
        end
        default: begin
          if (c == 8'hff) mode = 2'd0;
          if (c == 8'h90) mode = 2'd1;
          if (c == 8'h70) mode = 2'd2;
          if (c == 8'h50) begin
            fl = 3'h0;
            mode = 2'd0;
          end
          if (c == 8'h40 || c == 8'h10) ph = 1;
          if (c == 8'h20) ph = 2;
        end
      endcase
    end
    wsel = !ce_n && !we_n;
  end
  always @(negedge rp_n) begin
    ph = 0;
    mode = 0;
    fl = 0;
  end
  always @(negedge oe_n or negedge ce_n) begin
    if (!oe_n && !ce_n) begin
      tick();
      stl = {ph != 3 && ph != 4, ph == 5, fl, 3'h0};
    end
  end
  // released bus shows the complement of the last read value, never the stale value
  always @(ce_n or oe_n or we_n or rp_n or addr or mode or stl or byte_n) begin
    if (!ce_n && !oe_n && we_n && rp_n) begin
      val = mode == 2'd1 ? (addr[0] ? dev_code : mfr_code) : mode == 2'd2 ? {8'h00, stl} : mem[addr[3:0]];
      dout = byte_n ? val : {~last[15:8], val[7:0]};
      last = dout;
    end else dout = ~last;
  end
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Purpose: self-checking bench for the flash host
// Assumes: flash model behind the pins, software port driven here
// Notes: reads scored by a monitor against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_top import flash_host_pkg::*;;
  localparam logic [15:0] mfr = 16'h005a; // arbitrary value
  localparam logic [15:0] dev = 16'h00a6; // arbitrary value
  logic clk, reset, sw_write, sw_read, fail_next, rd_q1;
  logic [3:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, v;
  logic [16:0] flash_addr, a, ea;
  logic chip_enable_n, output_enable_n, write_enable_n, reset_powerdown_n, byte_mode_n, data_io_bus_oe;
  logic [15:0] dio_out, dio_in, dev_out, d;
  logic [15:0] m [16];
  logic [63:0] notes [$];
  logic [63:0] nt;
  int n_mismatch, comparisons;
  assign dio_in = data_io_bus_oe ? dio_out : dev_out;
  always #5 clk = ~clk;
  flash_host dut (.clk(clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write),
    .sw_read(sw_read), .sw_rdata(sw_rdata), .flash_addr(flash_addr), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .reset_powerdown_n(reset_powerdown_n),
    .byte_mode_n(byte_mode_n), .data_io_bus_in(dio_in), .data_io_bus_out(dio_out), .data_io_bus_oe(data_io_bus_oe));
  flash_model #(.mfr_code(mfr), .dev_code(dev)) flash (.addr(flash_addr), .ce_n(chip_enable_n),
    .oe_n(output_enable_n), .we_n(write_enable_n), .rp_n(reset_powerdown_n), .byte_n(byte_mode_n),
    .din(dio_in), .dout(dev_out), .fail_next(fail_next));
  // ==========================================
  // monitor: a zero mask marks a poll, not scored
  always @(posedge clk) begin
    if (rd_q1) begin
      nt = notes.pop_front();
      if (nt[31:0] != 0) cmp(sw_rdata, nt);
    end
    rd_q1 <= sw_read;
  end
  task automatic cmp(input logic [31:0] got, input logic [63:0] n);
    comparisons++;
    if ((got & n[31:0]) !== n[63:32]) begin
      n_mismatch++;
      $display("[ERR] %0t read %h expected %h mask %h", $time, got, n[63:32], n[31:0]);
    end
  endtask
  // ==========================================
  // software port
  task automatic wr(input logic [3:0] i, input logic [31:0] x);
    @(posedge clk);
    sw_addr <= i;
    sw_wdata <= x;
    sw_write <= 1'b1;
    @(posedge clk);
    sw_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i, input logic [31:0] x, input logic [31:0] k);
    @(posedge clk);
    sw_addr <= i;
    sw_read <= 1'b1;
    notes.push_back({x, k});
    @(posedge clk);
    sw_read <= 1'b0;
  endtask
  task automatic op(input logic [3:0] c, input logic [16:0] ad, input logic [15:0] dt);
    wr(reg_addr_off, {15'h0, ad});
    wr(reg_wdata_off, {16'h0, dt});
    wr(reg_cmd_off, {28'h0, c});
    for (int t = 0; t < 400; t++) begin
      rd(reg_status_off, 32'h0, 32'h0);
      @(posedge clk);
      v = sw_rdata;
      if (v[8] === 1'b0) return;
    end
    n_mismatch++;
    $display("[ERR] %0t busy never cleared", $time);
  endtask
  task automatic chk_arr(input logic [16:0] ad, input logic [31:0] k, input logic cmd);
    if (cmd) op(op_read_array, ad, 16'h0);
    op(op_read, ad, 16'h0);
    rd(reg_rdata_off, {16'h0, m[ad[3:0]]} & k, k);
  endtask
  task automatic stat(input logic [31:0] x);
    op(op_read_status, 17'h0, 16'h0);
    rd(reg_status_off, x, 32'h0000_01ff);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #600_000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    {clk, sw_write, sw_read, fail_next, rd_q1, sw_addr, sw_wdata} = '0;
    reset = 1;
    n_mismatch = 0;
    comparisons = 0;
    for (int i = 0; i < 16; i++) m[i] = 16'h3c5a ^ (16'h0101 * 16'(i));
    repeat (16) @(posedge clk);
    reset <= 0;
    void'($urandom(32'h594a));
    repeat (2) @(posedge clk);
    rd(reg_ctrl_off, {30'h0, ctrl_reset_value}, 32'h0000_0003);
    a = 17'($urandom);
    d = 16'($urandom);
    chk_arr(a, 32'h0000_ffff, 1'b0);
    chk_arr(a ^ 17'h0_0003, 32'h0000_ffff, 1'b1);
    op(op_read_id, a & 17'h1_fffe, 16'h0);
    rd(reg_rdata_off, {16'h0, mfr}, 32'h0000_ffff);
    op(op_read_id, a | 17'h0_0001, 16'h0);
    rd(reg_rdata_off, {16'h0, dev}, 32'h0000_ffff);
    $display("test reads done");
    op(op_program, a, d);
    m[a[3:0]] = m[a[3:0]] & d;
    stat(32'h0000_0080);
    chk_arr(a, 32'h0000_ffff, 1'b1);
    op(op_program, a, 16'hffff);
    stat(32'h0000_0080);
    chk_arr(a, 32'h0000_ffff, 1'b1);
    op(op_abort_program, a ^ 17'h0_0004, 16'h0);
    chk_arr(a ^ 17'h0_0004, 32'h0000_ffff, 1'b1);
    $display("test program done");
    fail_next <= 1'b1;
    op(op_program, a, 16'h0000);
    fail_next <= 1'b0;
    stat(32'h0000_0090);
    wr(reg_ctrl_off, 32'h0000_0001);
    repeat (20) @(posedge clk);
    wr(reg_ctrl_off, 32'h0000_0003);
    repeat (20) @(posedge clk);
    chk_arr(a, 32'h0000_ffff, 1'b0);
    stat(32'h0000_0080);
    fail_next <= 1'b1;
    op(op_program, a, 16'h0000);
    fail_next <= 1'b0;
    op(op_clear_status, a, 16'h0);
    chk_arr(a, 32'h0000_ffff, 1'b0);
    stat(32'h0000_0080);
    $display("test status done");
    ea = {a[16:4], 2'b01, a[1:0]};
    op(op_erase, ea, 16'h0);
    for (int i = 4; i < 8; i++) m[i] = 16'hffff;
    chk_arr(ea ^ 17'h0_0003, 32'h0000_ffff, 1'b1);
    chk_arr(ea ^ 17'h0_0008, 32'h0000_ffff, 1'b1);
    op(op_resume, ea, 16'h0);
    rd(reg_status_off, 32'h0000_0200, 32'h0000_0200);
    $display("test erase done");
    wr(reg_ctrl_off, 32'h0000_0002);
    chk_arr(ea, 32'h0000_00ff, 1'b1);
    wr(4'hf, 32'hffff_ffff);
    rd(reg_ctrl_off, 32'h0000_0002, 32'h0000_0003);
    $display("test byte mode done");
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
